// ---- rtl/mrtu_slave.sv ----
/*
  Serial RTU slave: receiver, frame check, function decode,
  parameter access, timed reply through a two-entry buffer.
  Assumes parameter store on sys_clk answers reg_req with one
  reg_ack pulse at least one cycle later; baud_sel, unit_addr
  and scan range are static while frames are in flight.
*/
// Functional notes
// - frames coded per public application protocol
// - serve read holding, read input, diagnostics echo (subfunction 0 only)
// - serve write one, write many, read-write
// - broadcast writes executed, other broadcasts ignored
// - one selected rate from eight standard rates
// - direct access reply after about 25 ms
// - scan range reads answered after about 3 ms
// - every parameter reachable via register port
`timescale 1ns/1ps
`default_nettype none
module mrtu_slave
  import mrtu_pkg::*;
#(
  parameter int unsigned DIRECT_CYC = mrtu_pkg::DIRECT_DLY_CYC,
  parameter int unsigned SCAN_CYC   = mrtu_pkg::SCAN_DLY_CYC
) (
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  input  wire logic        rs485_rx,
  output logic             rs485_tx,
  output logic             rs485_de,
  input  wire logic [2:0]  baud_sel,
  input  wire logic [7:0]  unit_addr,
  input  wire logic [15:0] scan_base,
  input  wire logic [15:0] scan_len,
  output logic             reg_req,
  output logic             reg_we,
  output logic             reg_input,
  output logic [15:0]      reg_addr,
  output logic [15:0]      reg_wdata,
  input  wire logic        reg_ack,
  input  wire logic        reg_err,
  input  wire logic [15:0] reg_rdata
);
  import mrtu_pkg::*;

  // ------------------------------------------------------------
  // receiver
  // ------------------------------------------------------------
  logic [2:0]  sync_q;
  logic        rx_lvl_q, rx_busy_q, byte_stb_q, frm_err_q;
  logic [19:0] rx_cnt_q, sil_q;
  logic [3:0]  rx_bit_q;
  logic [7:0]  rx_sh_q;
  wire  [19:0] div = baud_div(baud_sel);
  wire  [19:0] t35 = t35_cyc(baud_sel);

  always_ff @(posedge sys_clk or negedge reset_n)
    if (!reset_n)
    begin
      sync_q   <= 3'h7;
      rx_lvl_q <= 1'b1;
    end
    else
    begin
      sync_q <= {sync_q[1:0], rs485_rx};
      if (sync_q[2] == sync_q[1])
        rx_lvl_q <= sync_q[1];
    end

  wire rx_tick = rx_busy_q && (rx_cnt_q == 20'h00000);
  wire rx_start = !rx_busy_q && !rx_lvl_q;

  always_ff @(posedge sys_clk or negedge reset_n)
    if (!reset_n)
    begin
      rx_busy_q  <= 1'b0;
      rx_cnt_q   <= 20'h00000;
      rx_bit_q   <= 4'h0;
      rx_sh_q    <= 8'h00;
      byte_stb_q <= 1'b0;
      frm_err_q  <= 1'b0;
    end
    else
    begin
      byte_stb_q <= rx_tick && (rx_bit_q == 4'h9) && rx_lvl_q;
      frm_err_q  <= rx_tick && (rx_bit_q == 4'h9) && !rx_lvl_q;
      if (rx_start)
      begin
        rx_busy_q <= 1'b1;
        rx_cnt_q  <= div >> 1;
        rx_bit_q  <= 4'h0;
      end
      else if (rx_busy_q && !rx_tick)
        rx_cnt_q <= rx_cnt_q - 20'h00001;
      else if (rx_tick)
      begin
        rx_cnt_q <= div - 20'h00001;
        rx_bit_q <= rx_bit_q + 4'h1;
        if (rx_bit_q != 4'h0 && rx_bit_q != 4'h9)
          rx_sh_q <= {rx_lvl_q, rx_sh_q[7:1]};
        if ((rx_bit_q == 4'h0 && rx_lvl_q) || rx_bit_q == 4'h9)
          rx_busy_q <= 1'b0;
      end
    end

  // silence after the last character closes the frame
  wire line_idle = !rx_busy_q && rx_lvl_q;
  wire sil_run   = line_idle && (sil_q < t35);
  always_ff @(posedge sys_clk or negedge reset_n)
    if (!reset_n)
      sil_q <= 20'h00000;
    else
      sil_q <= !line_idle ? 20'h00000 : sil_q + {19'h0, sil_run};

  // ------------------------------------------------------------
  // frame store and decode
  // ------------------------------------------------------------
  logic [7:0]  rx_mem [FRAME_MAX];
  logic [7:0]  tx_mem [FRAME_MAX];
  logic [8:0]  rx_len_q, tx_len_q, tx_idx_q;
  logic [15:0] rx_crc_q, tx_crc_q;
  logic        rx_bad_q;
  mrtu_state_t st_q;

  function automatic logic [15:0] word_at(input logic [7:0] i);
    return {rx_mem[i], rx_mem[8'(i + 8'h01)]};
  endfunction : word_at

  wire [7:0]  fc    = rx_mem[1];
  wire        bcast = (rx_mem[0] == BCAST_ADDR);
  wire [15:0] a0    = word_at(8'h02);
  wire [15:0] q0    = word_at(8'h04);
  wire [15:0] a1    = word_at(8'h06);
  wire [15:0] q1    = word_at(8'h08);
  wire is_rd   = (fc == FC_RD_HOLD) || (fc == FC_RD_INP);
  wire is_rw   = (fc == FC_RW_MULT);
  wire is_echo = (fc == FC_WR_ONE) || (fc == FC_WR_MULT);
  wire rd_ok   = (q0 != 16'h0000) && (q0 <= MAX_RD_QTY);
  wire wm_ok   = (q0 != 16'h0000) && (q0 <= MAX_WR_QTY)
              && (rx_mem[6] == 8'(q0 << 1));
  wire rw_ok   = rd_ok && (q1 != 16'h0000) && (q1 <= MAX_RW_WR)
              && (rx_mem[10] == 8'(q1 << 1));
  wire [7:0] parse_exc =
      is_rd                ? (rd_ok ? EXC_NONE : EXC_DATA)
    : (fc == FC_WR_ONE)    ? EXC_NONE
    : (fc == FC_WR_MULT)   ? (wm_ok ? EXC_NONE : EXC_DATA)
    : is_rw                ? (rw_ok ? EXC_NONE : EXC_DATA)
    : (fc == FC_DIAG)      ? ((a0 == DIAG_ECHO) ? EXC_NONE : EXC_FUNC)
    :                        EXC_FUNC;
  wire bc_ok = (is_echo || is_rw) && (parse_exc == EXC_NONE);
  wire [15:0] wr_n = (fc == FC_WR_ONE) ? 16'h0001
                   : (fc == FC_WR_MULT) ? q0 : is_rw ? q1 : 16'h0000;
  wire [7:0]  wr_p = (fc == FC_WR_ONE) ? 8'h04
                   : (fc == FC_WR_MULT) ? 8'h07 : 8'h0B;
  wire [15:0] rd_n = (is_rd || is_rw) ? q0 : 16'h0000;
  wire [8:0]  norm_len = (fc == FC_DIAG) ? rx_len_q - 9'h002
                       : is_echo ? 9'h006 : 9'(3 + (rd_n << 1));
  wire [16:0] scan_end = {1'b0, scan_base} + {1'b0, scan_len};
  wire scan_hit = is_rd && (a0 >= scan_base)
               && ({1'b0, a0} + {1'b0, q0} <= scan_end);
  wire own = (rx_mem[0] == unit_addr) && (unit_addr >= UNIT_MIN)
          && (unit_addr <= UNIT_MAX);
  wire eof = (st_q == S_RX) && sil_run && (sil_q == t35 - 20'h00001)
          && (rx_len_q != 9'h000);
  wire frame_good = !rx_bad_q && (rx_crc_q == 16'h0000)
                 && (rx_len_q >= 9'h004);
  wire frame_take = eof && frame_good && (own || bcast);

  always_ff @(posedge sys_clk)
    if (byte_stb_q && st_q == S_RX && !rx_len_q[8])
      rx_mem[rx_len_q[7:0]] <= rx_sh_q;

  always_ff @(posedge sys_clk or negedge reset_n)
    if (!reset_n)
    begin
      rx_len_q <= 9'h000;
      rx_crc_q <= CRC_INIT;
      rx_bad_q <= 1'b0;
    end
    // length survives into decode, diagnostic replies size from it
    else if (st_q != S_RX || (eof && !frame_take))
    begin
      rx_len_q <= 9'h000;
      rx_crc_q <= CRC_INIT;
      rx_bad_q <= 1'b0;
    end
    else
    begin
      if (byte_stb_q && !rx_len_q[8])
      begin
        rx_len_q <= rx_len_q + 9'h001;
        rx_crc_q <= crc_byte(rx_crc_q, rx_sh_q);
      end
      if (frm_err_q || (byte_stb_q && rx_len_q[8]))
        rx_bad_q <= 1'b1;
    end

  // ------------------------------------------------------------
  // execution and reply sequencing
  // ------------------------------------------------------------
  logic [15:0] wr_addr_q, wr_n_q, rd_addr_q, rd_n_q;
  logic [7:0]  wr_p_q, rd_p_q, rsp_fc_q, rsp_b2_q;
  logic        src_rx_q, bc_q, pend_q, scan_q;
  logic [23:0] dly_q;
  wire in_wr  = (st_q == S_WRITE);
  wire issue  = !pend_q && ((in_wr && wr_n_q != 16'h0000)
             || (st_q == S_READ && rd_n_q != 16'h0000));
  wire ack_ok = pend_q && reg_ack;
  wire [7:0] tx_byte = src_rx_q ? rx_mem[tx_idx_q[7:0]]
                     : (tx_idx_q == 9'h000) ? rx_mem[0]
                     : (tx_idx_q == 9'h001) ? rsp_fc_q
                     : (tx_idx_q == 9'h002) ? rsp_b2_q
                     : tx_mem[tx_idx_q[7:0]];
  wire tx_push = (st_q == S_SEND) || (st_q == S_CRCL) || (st_q == S_CRCH);
  wire [7:0] push_data = (st_q == S_CRCL) ? tx_crc_q[7:0]
                       : (st_q == S_CRCH) ? tx_crc_q[15:8] : tx_byte;
  logic buf_ready, buf_valid, tx_busy_q;
  logic [7:0] buf_data;
  wire push_ok = tx_push && buf_ready;

  always_ff @(posedge sys_clk)
    if (ack_ok && !in_wr)
    begin
      tx_mem[rd_p_q] <= reg_rdata[15:8];
      tx_mem[8'(rd_p_q + 8'h01)] <= reg_rdata[7:0];
    end

  always_ff @(posedge sys_clk or negedge reset_n)
    if (!reset_n)
    begin
      pend_q    <= 1'b0;
      reg_req   <= 1'b0;
      reg_we    <= 1'b0;
      reg_input <= 1'b0;
      reg_addr  <= 16'h0000;
      reg_wdata <= 16'h0000;
    end
    else
    begin
      pend_q  <= issue ? 1'b1 : (reg_ack ? 1'b0 : pend_q);
      reg_req <= issue;
      if (issue)
      begin
        reg_we    <= in_wr;
        reg_input <= (fc == FC_RD_INP) && !in_wr;
        reg_addr  <= in_wr ? wr_addr_q : rd_addr_q;
        reg_wdata <= word_at(wr_p_q);
      end
    end

  always_ff @(posedge sys_clk or negedge reset_n)
    if (!reset_n)
    begin
      st_q <= S_RX;
      {wr_addr_q, wr_n_q, rd_addr_q, rd_n_q} <= 64'h0;
      {wr_p_q, rd_p_q, rsp_fc_q, rsp_b2_q} <= 32'h0;
      {src_rx_q, bc_q, scan_q} <= 3'h0;
      tx_len_q <= 9'h000;
      tx_idx_q <= 9'h000;
      tx_crc_q <= CRC_INIT;
      dly_q    <= 24'h000000;
    end
    else
    begin
      if (dly_q != 24'h000000)
        dly_q <= dly_q - 24'h000001;
      case (st_q)
        S_RX:
          if (frame_take)
            st_q <= S_PARSE;
        S_PARSE:
        begin
          bc_q      <= bcast;
          scan_q    <= scan_hit;
          dly_q     <= scan_hit ? 24'(SCAN_CYC) : 24'(DIRECT_CYC);
          wr_addr_q <= is_rw ? a1 : a0;
          wr_n_q    <= wr_n;
          wr_p_q    <= wr_p;
          rd_addr_q <= a0;
          rd_n_q    <= rd_n;
          rd_p_q    <= 8'h03;
          rsp_fc_q  <= fc;
          rsp_b2_q  <= 8'(rd_n << 1);
          tx_len_q  <= norm_len;
          src_rx_q  <= is_echo || (fc == FC_DIAG);
          if (bcast && !bc_ok)
            st_q <= S_RX;
          else if (parse_exc != EXC_NONE)
          begin
            rsp_fc_q <= fc | EXC_FLAG;
            rsp_b2_q <= parse_exc;
            tx_len_q <= 9'h003;
            src_rx_q <= 1'b0;
            st_q     <= S_WAIT;
          end
          else
            st_q <= S_WRITE;
        end
        S_WRITE, S_READ:
          if (ack_ok && reg_err)
          begin
            rsp_fc_q <= fc | EXC_FLAG;
            rsp_b2_q <= EXC_ADDR;
            tx_len_q <= 9'h003;
            src_rx_q <= 1'b0;
            st_q     <= bc_q ? S_RX : S_WAIT;
          end
          else if (ack_ok && in_wr)
          begin
            wr_addr_q <= wr_addr_q + 16'h0001;
            wr_p_q    <= wr_p_q + 8'h02;
            wr_n_q    <= wr_n_q - 16'h0001;
          end
          else if (ack_ok)
          begin
            rd_addr_q <= rd_addr_q + 16'h0001;
            rd_p_q    <= rd_p_q + 8'h02;
            rd_n_q    <= rd_n_q - 16'h0001;
          end
          else if (in_wr && wr_n_q == 16'h0000)
            st_q <= S_READ;
          else if (!in_wr && rd_n_q == 16'h0000)
            st_q <= bc_q ? S_RX : S_WAIT;
        S_WAIT:
          if (dly_q == 24'h000000)
          begin
            tx_idx_q <= 9'h000;
            tx_crc_q <= CRC_INIT;
            st_q     <= S_SEND;
          end
        S_SEND:
          if (push_ok)
          begin
            tx_crc_q <= crc_byte(tx_crc_q, tx_byte);
            tx_idx_q <= tx_idx_q + 9'h001;
            if (tx_idx_q == tx_len_q - 9'h001)
              st_q <= S_CRCL;
          end
        S_CRCL:
          if (push_ok)
            st_q <= S_CRCH;
        S_CRCH:
          if (push_ok)
            st_q <= S_DRAIN;
        S_DRAIN:
          if (!buf_valid && !tx_busy_q)
            st_q <= S_RX;
        default:
          st_q <= S_RX;
      endcase
    end

  // ------------------------------------------------------------
  // transmitter
  // ------------------------------------------------------------
  logic [19:0] tx_cnt_q;
  logic [3:0]  tx_bit_q;
  logic [10:0] tx_sh_q;
  wire pop = buf_valid && !tx_busy_q;

  mrtu_buf2 #(.W(8)) u_buf (
    .sys_clk   (sys_clk),
    .reset_n   (reset_n),
    .in_valid  (tx_push),
    .in_ready  (buf_ready),
    .in_data   (push_data),
    .out_valid (buf_valid),
    .out_ready (!tx_busy_q),
    .out_data  (buf_data)
  );

  // two stop bits keep the frame 11 bits wide without parity
  always_ff @(posedge sys_clk or negedge reset_n)
    if (!reset_n)
    begin
      tx_busy_q <= 1'b0;
      tx_cnt_q  <= 20'h00000;
      tx_bit_q  <= 4'h0;
      tx_sh_q   <= 11'h7FF;
      rs485_tx  <= 1'b1;
      rs485_de  <= 1'b0;
    end
    else
    begin
      rs485_tx <= tx_busy_q ? tx_sh_q[0] : 1'b1;
      rs485_de <= tx_busy_q || buf_valid || (st_q == S_DRAIN) || tx_push;
      if (pop)
      begin
        tx_busy_q <= 1'b1;
        tx_sh_q   <= {2'h3, buf_data, 1'b0};
        tx_cnt_q  <= div - 20'h00001;
        tx_bit_q  <= 4'h0;
      end
      else if (tx_busy_q && tx_cnt_q != 20'h00000)
        tx_cnt_q <= tx_cnt_q - 20'h00001;
      else if (tx_busy_q)
      begin
        tx_cnt_q <= div - 20'h00001;
        tx_sh_q  <= {1'b1, tx_sh_q[10:1]};
        tx_bit_q <= tx_bit_q + 4'h1;
        if (tx_bit_q == 4'(TX_FRAME_BITS - 1))
          tx_busy_q <= 1'b0;
      end
    end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  logic [23:0] age_q;
  always_ff @(posedge sys_clk or negedge reset_n)
    if (!reset_n)
      age_q <= 24'h000000;
    else if (st_q == S_PARSE)
      age_q <= 24'h000000;
    else if (age_q != 24'hFFFFFF)
      age_q <= age_q + 24'h000001;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  a_line_driven: assert property (!rs485_tx |-> rs485_de)
    else $error("line low while driver off");
  a_req_pulse: assert property (reg_req |=> !reg_req)
    else $error("register request longer than one cycle");
  a_bcast_quiet: assert property ($rose(tx_push) |-> !bc_q)
    else $error("reply sent to broadcast");
  a_crc_drop: assert property (eof && rx_crc_q != 16'h0000 |=> st_q == S_RX)
    else $error("bad crc frame accepted");
  a_direct_time: assert property ($rose(st_q == S_SEND) && !scan_q
    |-> age_q >= 24'(DIRECT_CYC))
    else $error("direct reply too early");
  a_scan_time: assert property ($rose(st_q == S_SEND) && scan_q
    |-> age_q >= 24'(SCAN_CYC) && age_q <= 24'(SCAN_CYC) + 24'h000008)
    else $error("scan reply timing off");
  a_exc_len: assert property (st_q == S_SEND && rsp_fc_q[7]
    |-> tx_len_q == 9'h003 && !src_rx_q)
    else $error("exception reply malformed");
  a_fc_known: assert property (reg_req |-> fc == FC_RD_HOLD
    || fc == FC_RD_INP || fc == FC_WR_ONE || fc == FC_WR_MULT
    || fc == FC_RW_MULT)
    else $error("register access for unknown function");
  a_bit_time: assert property ($rose(tx_busy_q) |=> tx_busy_q [*8])
    else $error("character shorter than expected");
  a_reply_count: assert property ($rose(st_q == S_DRAIN)
    |-> tx_idx_q == tx_len_q)
    else $error("reply byte count differs from length");

  c_read_reply: cover property (st_q == S_PARSE && is_rd ##1 st_q == S_WRITE);
  c_write_many: cover property (reg_req && reg_we && fc == FC_WR_MULT);
  c_broadcast:  cover property (st_q == S_PARSE && bcast && bc_ok);
  c_exception:  cover property (st_q == S_SEND && rsp_fc_q[7]);
endmodule : mrtu_slave
`default_nettype wire

// ---- rtl/mrtu_pkg.sv ----
/*
  Constants, codes and timing for the serial slave port.
  Assumes a single 10 MHz system clock drives every user of it.
*/
`default_nettype none
package mrtu_pkg;
  // ------------------------------------------------------------
  // clock and timing
  // ------------------------------------------------------------
  localparam int unsigned CLK_HZ        = 10_000_000;
  localparam int unsigned CYC_PER_US    = CLK_HZ / 1_000_000;
  localparam int unsigned T35_FIXED_US  = 1750;
  localparam int unsigned T35_FIXED_CYC = CYC_PER_US * T35_FIXED_US;
  localparam int unsigned DIRECT_DLY_US = 25_000;
  localparam int unsigned SCAN_DLY_US   = 3_000;
  localparam int unsigned DIRECT_DLY_CYC = CYC_PER_US * DIRECT_DLY_US;
  localparam int unsigned SCAN_DLY_CYC   = CYC_PER_US * SCAN_DLY_US;
  localparam int unsigned CHAR_BITS_X2  = 77;
  localparam int unsigned TX_FRAME_BITS = 11;
  localparam int unsigned FRAME_MAX     = 256;
  // ------------------------------------------------------------
  // protocol codes
  // ------------------------------------------------------------
  localparam logic [7:0]  FC_RD_HOLD = 8'h03;
  localparam logic [7:0]  FC_RD_INP  = 8'h04;
  localparam logic [7:0]  FC_WR_ONE  = 8'h06;
  localparam logic [7:0]  FC_DIAG    = 8'h08;
  localparam logic [7:0]  FC_WR_MULT = 8'h10;
  localparam logic [7:0]  FC_RW_MULT = 8'h17;
  localparam logic [7:0]  BCAST_ADDR = 8'h00;
  localparam logic [7:0]  UNIT_MIN   = 8'h01;
  localparam logic [7:0]  UNIT_MAX   = 8'hF7;
  localparam logic [7:0]  EXC_NONE   = 8'h00;
  localparam logic [7:0]  EXC_FUNC   = 8'h01;
  localparam logic [7:0]  EXC_ADDR   = 8'h02;
  localparam logic [7:0]  EXC_DATA   = 8'h03;
  localparam logic [7:0]  EXC_FLAG   = 8'h80;
  localparam logic [15:0] DIAG_ECHO  = 16'h0000;
  localparam logic [15:0] MAX_RD_QTY = 16'h007D;
  localparam logic [15:0] MAX_WR_QTY = 16'h007B;
  localparam logic [15:0] MAX_RW_WR  = 16'h0079;
  localparam logic [15:0] CRC_INIT   = 16'hFFFF;
  localparam logic [15:0] CRC_POLY   = 16'hA001;
  localparam logic [2:0]  SEL_19200  = 3'h4;

  typedef enum logic [3:0] {
    S_RX, S_PARSE, S_WRITE, S_READ, S_WAIT, S_SEND, S_CRCL, S_CRCH, S_DRAIN
  } mrtu_state_t;

  // bit period in clock cycles for each baud select code
  function automatic logic [19:0] baud_div(input logic [2:0] sel);
    case (sel)
      3'h0:    return 20'(CLK_HZ / 1200);
      3'h1:    return 20'(CLK_HZ / 2400);
      3'h2:    return 20'(CLK_HZ / 4800);
      3'h3:    return 20'(CLK_HZ / 9600);
      3'h4:    return 20'(CLK_HZ / 19200);
      3'h5:    return 20'(CLK_HZ / 38400);
      3'h6:    return 20'(CLK_HZ / 57600);
      default: return 20'(CLK_HZ / 115200);
    endcase
  endfunction : baud_div

  // inter-frame silence: 3.5 chars, fixed above 19200 baud
  function automatic logic [19:0] t35_cyc(input logic [2:0] sel);
    if (sel > SEL_19200)
      return 20'(T35_FIXED_CYC);
    return 20'((32'(baud_div(sel)) * CHAR_BITS_X2 + 1) / 2);
  endfunction : t35_cyc

  function automatic logic [15:0] crc_byte(input logic [15:0] c,
                                           input logic [7:0]  b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++)
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    return r;
  endfunction : crc_byte
endpackage : mrtu_pkg
`default_nettype wire

// ---- rtl/mrtu_buf2.sv ----
/*
  Two-entry buffer with valid/ready on both sides.
  Assumes both sides share sys_clk; full drops in_ready.
*/
`timescale 1ns/1ps
`default_nettype none
module mrtu_buf2 #(
  parameter int unsigned W = 8
) (
  input  wire logic         sys_clk,
  input  wire logic         reset_n,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  logic [W-1:0] mem_q [2];
  logic         rd_q;
  logic         wr_q;
  logic [1:0]   cnt_q;
  wire          push = in_valid && in_ready;
  wire          pop  = out_valid && out_ready;

  assign in_ready  = (cnt_q != 2'h2);
  assign out_valid = (cnt_q != 2'h0);
  assign out_data  = mem_q[rd_q];

  always_ff @(posedge sys_clk or negedge reset_n)
    if (!reset_n)
    begin
      rd_q  <= 1'b0;
      wr_q  <= 1'b0;
      cnt_q <= 2'h0;
    end
    else
    begin
      rd_q  <= rd_q ^ pop;
      wr_q  <= wr_q ^ push;
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end

  always_ff @(posedge sys_clk)
    if (push)
      mem_q[wr_q] <= in_data;

  a_first_word: assert property (@(posedge sys_clk) disable iff (!reset_n)
    push && cnt_q == 2'h0 |=> out_data == $past(in_data))
    else $error("buffer word lost");
endmodule : mrtu_buf2
`default_nettype wire

// ---- testbench/mrtu_master_model.sv ----
/*
  Serial master model: sends request bytes, collects reply bytes.
  Assumes the bus idles high when the slave is not driving.
*/
`timescale 1ns/1ps
`default_nettype none
module mrtu_master_model #(
  parameter int DIV = 86
) (
  input  wire logic sys_clk,
  input  wire logic line_in,
  output var logic  line_out
);
  initial line_out = 1'b1;
  // start, 8 data lsb first, stop; one rate on both ends
  task automatic put(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      line_out <= f[i];
      repeat (DIV) @(posedge sys_clk);
    end
  endtask : put
  // gives up after lim idle cycles, so a silent slave ends the wait
  task automatic get(input int lim, output logic [7:0] b,
                     output logic ok);
    int n;
    n = 0;
    b = 8'h00;
    while (line_in === 1'b1 && n < lim)
    begin
      @(posedge sys_clk);
      n++;
    end
    ok = (n < lim);
    if (ok)
    begin
      repeat (DIV / 2) @(posedge sys_clk);
      for (int i = 0; i < 8; i++)
      begin
        repeat (DIV) @(posedge sys_clk);
        b[i] = line_in;
      end
      repeat (DIV) @(posedge sys_clk);
    end
  endtask : get
endmodule : mrtu_master_model
`default_nettype wire

// ---- testbench/tb.sv ----
/*
  Bench: broadcast write, read and bad function code over the line.
  Assumes mrtu_pkg and the master model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  import mrtu_pkg::*;
  localparam int DIV = CLK_HZ / 115200;
  logic        sys_clk, reset_n, m_tx, s_tx, s_de, de_seen;
  logic        req, we, inp, ack, err;
  logic [15:0] addr, wdata, rdata, scan_lo;
  logic [7:0]  rq[$];
  logic [7:0]  rp[$];
  logic [7:0]  ex[$];
  int          err_count, n_compared, n_req, n0;
  wire logic   line = s_de ? s_tx : 1'b1;

  mrtu_slave #(.DIRECT_CYC(200), .SCAN_CYC(50)) mrtu_slave_i (
    .sys_clk(sys_clk), .reset_n(reset_n), .rs485_rx(m_tx),
    .rs485_tx(s_tx), .rs485_de(s_de), .baud_sel(3'h7),
    .unit_addr(8'h2A), .scan_base(scan_lo), .scan_len(16'h0010),
    .reg_req(req), .reg_we(we), .reg_input(inp), .reg_addr(addr),
    .reg_wdata(wdata), .reg_ack(ack), .reg_err(err),
    .reg_rdata(rdata));
  mrtu_master_model #(.DIV(DIV)) mrtu_master_model_i (
    .sys_clk(sys_clk), .line_in(line), .line_out(m_tx));

  initial
  begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end
  // store answers one cycle after each request
  always @(posedge sys_clk)
  begin
    ack   <= req;
    rdata <= addr ^ 16'h5A5A;
    if (req)
      n_req <= n_req + 1;
    if (s_de)
      de_seen <= 1'b1;
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [15:0] crc(input logic [7:0] q[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (q[i])
    begin
      c ^= {8'h00, q[i]};
      for (int k = 0; k < 8; k++)
        c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
    end
    return c;
  endfunction : crc
  task automatic chk(input string nm, input logic [15:0] e, g);
    n_compared++;
    if (g !== e)
    begin
      err_count++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  // crc low byte first on both directions
  task automatic xfer(input int n, input int lim);
    logic [15:0] c;
    logic [7:0]  b;
    logic        ok;
    c = crc(rq);
    rq.push_back(c[7:0]);
    rq.push_back(c[15:8]);
    rp = {};
    n0 = n_req;
    foreach (rq[i])
      mrtu_master_model_i.put(rq[i]);
    ok = 1'b1;
    while (ok && rp.size() < n)
    begin
      mrtu_master_model_i.get(lim, b, ok);
      if (ok)
        rp.push_back(b);
    end
  endtask : xfer
  task automatic chk_rep();
    logic [15:0] c;
    c = crc(ex);
    ex.push_back(c[7:0]);
    ex.push_back(c[15:8]);
    chk("reply len", 16'(ex.size()), 16'(rp.size()));
    foreach (ex[i])
      if (i < rp.size())
        chk("reply byte", {8'h00, ex[i]}, {8'h00, rp[i]});
  endtask : chk_rep
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_bcast();
    de_seen = 1'b0;
    // store refuses the write: a broadcast must still stay silent
    err <= 1'b1;
    rq = {8'h00, FC_WR_ONE, 8'h00, 8'h30, 8'h12, 8'h34};
    xfer(1, 20000);
    chk("bcast reply", 16'h0000, 16'(rp.size()));
    chk("bcast de", 16'h0000, {15'h0000, de_seen});
    chk("bcast writes", 16'h0001, 16'(n_req - n0));
    chk("bcast addr", 16'h0030, addr);
    chk("bcast data", 16'h1234, wdata);
    chk("bcast we", 16'h0001, {15'h0000, we});
  endtask : t_bcast
  task automatic t_read();
    err <= 1'b0;
    // range 0x18..0x27 holds the read, so the short delay applies
    scan_lo <= 16'h0018;
    rq = {8'h2A, FC_RD_HOLD, 8'h00, 8'h20, 8'h00, 8'h01};
    xfer(7, 25000);
    ex = {8'h2A, 8'h03, 8'h02, 8'h5A, 8'h7A};
    chk_rep();
    chk("rd reqs", 16'h0001, 16'(n_req - n0));
    chk("rd addr", 16'h0020, addr);
    chk("rd we inp", 16'h0000, {14'h0000, we, inp});
  endtask : t_read
  task automatic t_badfc();
    rq = {8'h2A, 8'h05, 8'h00, 8'h00, 8'h00, 8'h01};
    xfer(5, 25000);
    ex = {8'h2A, 8'h85, 8'h01};
    chk_rep();
    chk("bad fc reqs", 16'h0000, 16'(n_req - n0));
  endtask : t_badfc
  task automatic summarize();
    $display("errors %0d compared %0d", err_count, n_compared);
    if (err_count == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : summarize

  initial
  begin
    reset_n = 1'b0;
    ack = 1'b0;
    err = 1'b0;
    rdata = 16'h0000;
    scan_lo = 16'h0100;
    n_req = 0;
    err_count = 0;
    n_compared = 0;
    repeat (3) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    t_bcast();
    t_read();
    // idle gap after a reply before the next request
    repeat (4000) @(posedge sys_clk);
    t_badfc();
    summarize();
  end
  initial
  begin
    repeat (100000) @(posedge sys_clk);
    err_count++;
    summarize();
  end
endmodule : tb
`default_nettype wire
